// >>> verilog/csfc_top.v
// Serial frame configuration and word/frame/buffer counting for a codec serial port.
// Assumes a register master on core_clk and a free-running serial bit clock on a pin.
// Assumes software keeps word bit size codes at 0011 or above.
//
// How it works
// - Buffer word count code n raises an interrupt after n+1 words, giving one to four words.
// - Frame word count code n makes a frame of n+1 words, one to sixteen.
// - Word bit size code n makes each word n+1 bits, four to sixteen.
// - Reserved config bits 15..12, 9 and 4 read as zero and all fields reset to zero.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "csfc_map.vh"
module csfc_top (
   input wire core_clk,
   input wire srst,
   input wire [3:0] addr,
   input wire [15:0] wdata,
   input wire wr_en,
   input wire rd_en,
   output reg [15:0] rdata,
   input wire sclk_pin,
   output reg frame_sync,
   output reg word_done,
   output reg irq
);
   // ************************************************************
   // Registers
   // ************************************************************
   reg [15:0] cfg_r;
   reg [15:0] cfg_nxt;
   reg [1:0] status_r;
   reg [1:0] status_nxt;
   reg [1:0] mask_r;
   reg [1:0] mask_nxt;
   reg enable_r;
   reg enable_nxt;
   reg irq_nxt;
   wire [1:0] buf_code;
   wire [3:0] frm_code;
   wire [3:0] ws_code;
   wire [15:0] cfg_view;
   wire wr_cfg;
   wire wr_status;
   wire wr_mask;
   wire wr_ctrl;
   assign buf_code = cfg_r[`CSFC_BUF_HI:`CSFC_BUF_LO];
   assign frm_code = cfg_r[`CSFC_FRM_HI:`CSFC_FRM_LO];
   assign ws_code = cfg_r[`CSFC_WS_HI:`CSFC_WS_LO];
   // Reserved positions are tied to zero here rather than trusted to the write mask
   assign cfg_view = {4'h0, buf_code, 1'b0, frm_code, 1'b0, ws_code};
   // Write decode; a read strobe never changes state
   assign wr_cfg = wr_en & (addr == `CSFC_REG_FRAME_CFG);
   assign wr_status = wr_en & (addr == `CSFC_REG_STATUS);
   assign wr_mask = wr_en & (addr == `CSFC_REG_MASK);
   assign wr_ctrl = wr_en & (addr == `CSFC_REG_CTRL);

   // ************************************************************
   // Link clock sampling
   // ************************************************************
   // Two flops before use; edge found on the second and third stages
   reg sclk_s1_r;
   reg sclk_s2_r;
   reg sclk_s3_r;
   wire bit_tick;
   always @(posedge core_clk) begin
      if (srst) begin
         sclk_s1_r <= 1'b0;
         sclk_s2_r <= 1'b0;
         sclk_s3_r <= 1'b0;
      end else begin
         sclk_s1_r <= sclk_pin;
         sclk_s2_r <= sclk_s1_r;
         sclk_s3_r <= sclk_s2_r;
      end
   end
   // Stages reset to the idle low level of the link clock, so no false edge follows reset
   assign bit_tick = sclk_s2_r & ~sclk_s3_r;

   // ************************************************************
   // Word, frame and buffer counters
   // ************************************************************
   reg [3:0] bit_cnt_r;
   reg [3:0] bit_cnt_nxt;
   reg [3:0] word_cnt_r;
   reg [3:0] word_cnt_nxt;
   reg [1:0] buf_cnt_r;
   reg [1:0] buf_cnt_nxt;
   reg frame_sync_nxt;
   reg word_done_nxt;
   wire word_end;
   wire frame_end;
   wire buf_end;
   // Codes below 0011 are not guarded; counting simply follows the code
   assign word_end = enable_r & bit_tick & (bit_cnt_r == ws_code);
   assign frame_end = word_end & (word_cnt_r == frm_code);
   assign buf_end = word_end & (buf_cnt_r == buf_code);
   always @* begin
      bit_cnt_nxt = bit_cnt_r;
      word_cnt_nxt = word_cnt_r;
      buf_cnt_nxt = buf_cnt_r;
      frame_sync_nxt = 1'b0;
      word_done_nxt = word_end;
      if (!enable_r) begin
         // Held at zero while disabled, so enabling always starts on a word boundary
         bit_cnt_nxt = 4'h0;
         word_cnt_nxt = 4'h0;
         buf_cnt_nxt = 2'h0;
      end else if (word_end) begin
         bit_cnt_nxt = 4'h0;
         if (frame_end) begin
            word_cnt_nxt = 4'h0;
         end else begin
            word_cnt_nxt = word_cnt_r + 4'h1;
         end
         if (buf_end) begin
            buf_cnt_nxt = 2'h0;
         end else begin
            buf_cnt_nxt = buf_cnt_r + 2'h1;
         end
         frame_sync_nxt = frame_end;
      end else if (bit_tick) begin
         bit_cnt_nxt = bit_cnt_r + 4'h1;
      end
   end
   always @(posedge core_clk) begin
      if (srst) begin
         bit_cnt_r <= 4'h0;
         word_cnt_r <= 4'h0;
         buf_cnt_r <= 2'h0;
         frame_sync <= 1'b0;
         word_done <= 1'b0;
      end else begin
         bit_cnt_r <= bit_cnt_nxt;
         word_cnt_r <= word_cnt_nxt;
         buf_cnt_r <= buf_cnt_nxt;
         frame_sync <= frame_sync_nxt;
         word_done <= word_done_nxt;
      end
   end

   // ************************************************************
   // Register writes and sticky status
   // ************************************************************
   always @* begin
      cfg_nxt = cfg_r;
      mask_nxt = mask_r;
      enable_nxt = enable_r;
      if (wr_cfg) begin
         cfg_nxt = wdata & `CSFC_CFG_WMASK;
      end
      if (wr_mask) begin
         mask_nxt = wdata[1:0];
      end
      if (wr_ctrl) begin
         enable_nxt = wdata[`CSFC_CTRL_EN];
      end
   end
   always @* begin
      status_nxt = status_r;
      if (wr_status) begin
         status_nxt = status_r & ~wdata[1:0];
      end
      // Hardware set wins over a same-cycle clear, so no event is lost
      if (buf_end) begin
         status_nxt[`CSFC_ST_BUF] = 1'b1;
      end
      if (frame_end) begin
         status_nxt[`CSFC_ST_FRM] = 1'b1;
      end
   end
   always @(posedge core_clk) begin
      if (srst) begin
         cfg_r <= `CSFC_CFG_RST;
         status_r <= `CSFC_ST_RST;
         mask_r <= `CSFC_ST_RST;
         enable_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         status_r <= status_nxt;
         mask_r <= mask_nxt;
         enable_r <= enable_nxt;
      end
   end

   // ************************************************************
   // Interrupt output
   // ************************************************************
   // Uses the next mask, so a mask write acts on the same edge as a status write
   always @* begin
      irq_nxt = |(status_nxt & mask_nxt);
   end
   always @(posedge core_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_nxt;
      end
   end

   // ************************************************************
   // Register reads
   // ************************************************************
   reg [15:0] rdata_nxt;
   always @* begin
      rdata_nxt = 16'h0000;
      if (rd_en) begin
         case (addr)
            `CSFC_REG_FRAME_CFG: rdata_nxt = cfg_view;
            `CSFC_REG_STATUS: rdata_nxt = {14'h0000, status_r};
            `CSFC_REG_MASK: rdata_nxt = {14'h0000, mask_r};
            `CSFC_REG_CTRL: rdata_nxt = {15'h0000, enable_r};
            default: rdata_nxt = 16'h0000;
         endcase
      end
   end
   // Data stand for one cycle only and are zero otherwise, so an OR-ed read bus stays clean
   always @(posedge core_clk) begin
      if (srst) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= rdata_nxt;
      end
   end
endmodule
`default_nettype wire

// >>> verilog/csfc_map.vh
// Register map, field positions and reset values of the serial frame configuration block.
// Assumes inclusion by the block's design file only.
`ifndef CSFC_MAP_VH
`define CSFC_MAP_VH
// Register word indices on the plain register port
`define CSFC_ADDR_W 4
`define CSFC_REG_FRAME_CFG 4'h0
`define CSFC_REG_STATUS 4'h1
`define CSFC_REG_MASK 4'h2
`define CSFC_REG_CTRL 4'h3
// Frame configuration fields
`define CSFC_BUF_HI 11
`define CSFC_BUF_LO 10
`define CSFC_FRM_HI 8
`define CSFC_FRM_LO 5
`define CSFC_WS_HI 3
`define CSFC_WS_LO 0
`define CSFC_CFG_WMASK 16'h0DEF
`define CSFC_CFG_RST 16'h0000
// Status and mask bits
`define CSFC_ST_BUF 0
`define CSFC_ST_FRM 1
`define CSFC_ST_W 2
`define CSFC_ST_RST 2'h0
// Control bits
`define CSFC_CTRL_EN 0
`endif

// >>> testbench/csfc_checker.sv
// Assertions on the frame configuration block ports.
// Assumes a bind to csfc_top and word ends more than eight core cycles apart.
`timescale 1ns/1ps
`default_nettype none
module csfc_checker (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [3:0] addr,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [15:0] rdata,
   input wire logic frame_sync,
   input wire logic word_done,
   input wire logic irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   AST_RSVD_ZERO: assert property (rd_en && addr == 4'h0 |=> (rdata & 16'hf210) == 16'h0000)
      else $error("reserved config bits read back set");
   AST_RST_QUIET: assert property ($fell(srst) |-> !irq && !word_done)
      else $error("outputs active after reset");
   AST_WORD_GAP: assert property (word_done |=> !word_done [*8])
      else $error("words closer than one bit period");
   AST_FRAME_WORD: assert property (frame_sync |-> word_done)
      else $error("frame end without word end");
   AST_IRQ_CLEAR: assert property ($fell(irq) |-> $past(wr_en) || $past(wr_en, 2))
      else $error("interrupt dropped without a write");
endmodule
`default_nettype wire

// >>> testbench/csfc_link_model.sv
// Serial bit clock source in place of the external codec.
// Assumes run comes from the bench; the clock stands low while run is low.
`timescale 1ns/1ps
`default_nettype none
module csfc_link_model (
   input wire logic run,
   output logic sclk
);
   initial begin
      sclk = 1'b0;
      forever begin
         #16;
         sclk = run ? ~sclk : 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the frame configuration block.
// Assumes the link model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic core_clk = 1'b0, srst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, run = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] st_exp;
   wire [15:0] rdata;
   wire sclk, frame_sync, word_done, irq;
   int err_total = 0, checks_done = 0, nw = 0, nf = 0, nb = 0, cyc = 0, w0, f0, b0;
   csfc_top csfc_top_inst (.core_clk(core_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .sclk_pin(sclk), .frame_sync(frame_sync), .word_done(word_done), .irq(irq));
   csfc_link_model csfc_link_model_inst (.run(run), .sclk(sclk));
   initial forever #2 core_clk = ~core_clk;
   always @(posedge sclk) nb++;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      nw <= nw + word_done;
      nf <= nf + frame_sync;
      // Ceiling about four times the expected run length
      if (cyc == 5000) begin
         err_total++;
         $display("mismatch %0t timeout", $time);
         results;
      end
   end
   task chk(input logic [15:0] v, input logic [15:0] e);
      checks_done++;
      if (v !== e) begin
         err_total++;
         $display("mismatch %0t got %h exp %h", $time, v, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task run_case(input logic [15:0] cfg, input logic [15:0] msk, input int bits, input int words,
      input int frames, input logic [15:0] st);
      wr(4'h3, 16'h0000);
      wr(4'h1, 16'h0003);
      wr(4'h0, cfg);
      wr(4'h2, msk);
      w0 = nw;
      f0 = nf;
      b0 = nb;
      wr(4'h3, 16'h0001);
      run <= 1'b1;
      for (int i = 0; i < 1000 && irq !== 1'b1; i++) @(posedge core_clk);
      chk(16'(nb - b0), 16'(bits));
      run <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk(16'(nw - w0), 16'(words));
      chk(16'(nf - f0), 16'(frames));
      rd(4'h1, st);
      wr(4'h1, 16'h0003);
      repeat (2) @(posedge core_clk);
      #1 chk({15'h0000, irq}, 16'h0000);
      $display("test link cfg %h done", cfg);
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      rd(4'h0, 16'h0000);
      rd(4'h1, 16'h0000);
      wr(4'h0, 16'hffff);
      rd(4'h0, 16'h0def);
      rd(4'h7, 16'h0000);
      $display("test registers done");
      wr(4'h2, 16'h0003);
      wr(4'h3, 16'h0001);
      rd(4'h2, 16'h0003);
      rd(4'h3, 16'h0001);
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      rd(4'h0, 16'h0000);
      rd(4'h2, 16'h0000);
      rd(4'h3, 16'h0000);
      $display("test reset done");
      for (int b = 0; b < 4; b++) begin
         st_exp = (b == 0) ? 16'h0001 : 16'h0003;
         run_case(16'(b << 10) | 16'h0023, 16'h0001, (b + 1) * 4, b + 1, (b + 1) / 2, st_exp);
      end
      run_case(16'h000f, 16'h0001, 16, 1, 1, 16'h0003);
      run_case(16'h0de4, 16'h0002, 80, 16, 1, 16'h0003);
      results;
   end
endmodule
bind csfc_top csfc_checker csfc_checker_inst (.core_clk(core_clk), .srst(srst), .addr(addr), .wr_en(wr_en),
   .rd_en(rd_en), .rdata(rdata), .frame_sync(frame_sync), .word_done(word_done), .irq(irq));
`default_nettype wire
